// ==== logic/pbcd_pkg.sv ====
// Package: constants, types and register map of the BAR decode block
// Functional notes
// - Endpoint: six 32-bit or three 64-bit BARs
// - Root Port: two 32-bit or one 64-bit BAR
// - Each of slots zero to five holds 32 bits
// - Endpoint 32-bit window 128 bytes to 2 GB
// - 64-bit window up to 8 EB, memory only
// - Memory minimum 128 bytes, Legacy 16 bytes
// - I/O BAR is 32-bit, never prefetchable
// - I/O only in Legacy, minimum 16 bytes
// - 64-bit BAR consumes next slot as upper half
// - Claim only requests of the BAR's space type
// - Deselected BAR is disabled, claims nothing
// - Non-Legacy prefetchable BARs below BAR5 are 64-bit
// - ROM window 2K to 4G, flag over 16M
// - Prefetchable claims marked mergeable, no read effects
package pbcd_pkg;

   localparam int NSLOT = 6;
   localparam int NREG = 7;
   localparam int RP_SLOTS = 2;
   localparam int SETUP_W = 10;
   localparam logic [2:0] CLAIM_ROM = 3'h6;

   typedef enum logic [1:0]
   {
      PBCD_EP = 2'h0,
      PBCD_LEGACY = 2'h1,
      PBCD_ROOT = 2'h2
   } pbcd_port_e;

   // Register byte offsets; setup and BAR words are seven consecutive words each
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_SETUP0 = 8'h10;
   localparam logic [7:0] A_BAR0 = 8'h40;

   // Setup word fields
   localparam int F_EN = 0;
   localparam int F_IO = 1;
   localparam int F_W64 = 2;
   localparam int F_PF = 3;
   localparam int F_SZ = 4;
   localparam int SZ_W = 6;

   // Status word fields
   localparam int S_EN = 0;
   localparam int S_ERR = 8;
   localparam int S_ROMBIG = 16;

   // Reset values
   localparam pbcd_port_e RST_CTRL = PBCD_EP;
   localparam logic [SETUP_W-1:0] RST_SETUP = 10'h000;
   localparam logic [31:0] RST_BAR = 32'h0000_0000;

   // Window limits as log2 of bytes
   localparam logic [5:0] SZ_MIN_EP = 6'h07;
   localparam logic [5:0] SZ_MIN_LEG = 6'h04;
   localparam logic [5:0] SZ_MAX32 = 6'h1f;
   localparam logic [5:0] SZ_MAX64 = 6'h3f;
   localparam logic [5:0] ROM_MIN = 6'h0b;
   localparam logic [5:0] ROM_MAX = 6'h20;
   localparam logic [5:0] ROM_ADVISE = 6'h18;

   // Attribute bits in the low BAR word
   localparam int B_IO = 0;
   localparam int B_PF = 3;
   localparam logic [1:0] B_TYPE64 = 2'h2;
   localparam int B_ROMDEC = 0;

endpackage

// ==== logic/pbcd_slot_check.sv ====
// Legality check and effective attributes of one BAR slot
`timescale 1ns/1ns
module pbcd_slot_check
#(
   parameter int SLOT = 0
)
(
   // Software setup
   input wire logic [pbcd_pkg::SETUP_W-1:0] setup,
   input wire pbcd_pkg::pbcd_port_e port,
   input wire logic upper,
   // Effective attributes
   output logic en,
   output logic io,
   output logic w64,
   output logic pf,
   output logic [5:0] size,
   output logic err
);
   import pbcd_pkg::*;

   logic bad;
   logic legacy;
   int limit;
   logic [5:0] raw;
   logic [5:0] lo;
   logic [5:0] hi;

   always_comb
   begin
      legacy = (port == PBCD_LEGACY);
      limit = (port == PBCD_ROOT) ? RP_SLOTS : NSLOT;
      io = setup[F_IO];
      w64 = setup[F_W64] & ~io;
      pf = setup[F_PF] & ~io;
      bad = 1'b0;
      if (io && !legacy)
      begin
         bad = 1'b1;
      end
      if (SLOT >= limit || (w64 && SLOT + 1 >= limit))
      begin
         bad = 1'b1;
      end
      if (pf && !w64 && !legacy && SLOT != NSLOT - 1)
      begin
         bad = 1'b1;
      end
      raw = setup[F_SZ +: SZ_W];
      lo = legacy ? SZ_MIN_LEG : SZ_MIN_EP;
      hi = w64 ? SZ_MAX64 : SZ_MAX32;
      size = (raw < lo) ? lo : ((raw > hi) ? hi : raw);
      en = setup[F_EN] & ~upper & ~bad;
      err = setup[F_EN] & ~upper & bad;
   end

endmodule

// ==== logic/pbcd_addr_match.sv ====
// Address compare of one power-of-two window
`timescale 1ns/1ns
module pbcd_addr_match
(
   // Window
   input wire logic en,
   input wire logic [63:0] base,
   input wire logic [5:0] size,
   // Request address
   input wire logic [63:0] addr,
   output logic hit
);
   logic [63:0] keep;

   always_comb
   begin
      keep = ~((64'h1 << size) - 64'h1);
      hit = en && (((addr ^ base) & keep) == 64'h0);
   end

endmodule

// ==== logic/pbcd_bar_decode.sv ====
// BAR register bank with AHB-Lite access and request claim logic
`timescale 1ns/1ns
module pbcd_bar_decode
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SRST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Incoming request
   input wire logic REQ_VALID,
   input wire logic [63:0] REQ_ADDR,
   input wire logic REQ_IO,
   // Claim answer
   output logic CLAIM_VALID,
   output logic CLAIM_HIT,
   output logic [2:0] CLAIM_BAR,
   output logic CLAIM_PREFETCH
);
   import pbcd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic in_block(input logic [7:0] a, input logic [7:0] b);
      in_block = (a >= b) && (a < b + 8'h1c);
   endfunction

   function automatic logic [2:0] blk_idx(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] d;
      d = a - b;
      blk_idx = d[4:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus phase tracking

   logic ap;
   logic mapped;
   logic wp_r;
   logic wp_nxt;
   logic [7:0] wa_r;
   logic [7:0] wa_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;

   always_comb
   begin
      ap = HSEL && HREADY && HTRANS[1];
      mapped = (HADDR[31:8] == 24'h0) && (HADDR[1:0] == 2'h0) && (HSIZE == 3'h2);
      wp_nxt = ap && HWRITE && mapped;
      wa_nxt = ap ? HADDR[7:0] : wa_r;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         wp_r <= 1'b0;
         wa_r <= 8'h00;
      end
      else
      begin
         wp_r <= wp_nxt;
         wa_r <= wa_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register storage; index 6 of each array is the expansion ROM

   pbcd_port_e ctrl_r;
   pbcd_port_e ctrl_nxt;
   logic [SETUP_W-1:0] setup_r [0:NREG-1];
   logic [SETUP_W-1:0] setup_nxt [0:NREG-1];
   logic [31:0] base_r [0:NREG-1];
   logic [31:0] base_nxt [0:NREG-1];

   always_comb
   begin
      ctrl_nxt = ctrl_r;
      setup_nxt = setup_r;
      base_nxt = base_r;
      if (wp_r)
      begin
         if (wa_r == A_CTRL && HWDATA[1:0] != 2'h3)
         begin
            ctrl_nxt = pbcd_port_e'(HWDATA[1:0]);
         end
         if (in_block(wa_r, A_SETUP0))
         begin
            setup_nxt[blk_idx(wa_r, A_SETUP0)] = HWDATA[SETUP_W-1:0];
         end
         if (in_block(wa_r, A_BAR0))
         begin
            base_nxt[blk_idx(wa_r, A_BAR0)] = HWDATA;
         end
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         ctrl_r <= RST_CTRL;
         setup_r <= '{default: RST_SETUP};
         base_r <= '{default: RST_BAR};
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         setup_r <= setup_nxt;
         base_r <= base_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Effective slot configuration and read-back values

   logic [NSLOT-1:0] eff_en;
   logic [NSLOT-1:0] eff_io;
   logic [NSLOT-1:0] eff_w64;
   logic [NSLOT-1:0] eff_pf;
   logic [NSLOT-1:0] eff_err;
   logic [NSLOT-1:0] upper;
   logic [NSLOT-1:0] hit;
   logic [5:0] eff_size [0:NSLOT-1];
   logic [63:0] low_mask [0:NSLOT-1];
   logic [31:0] rb [0:NREG-1];

   genvar gi;
   generate
      for (gi = 0; gi < NSLOT; gi++)
      begin : g_slot
         logic [63:0] base64;
         logic [31:0] up_mask;
         // Slot zero has no partner below; a constant keeps the index in range
         if (gi == 0)
         begin : g_first
            assign upper[gi] = 1'b0;
            assign up_mask = 32'h0;
         end
         else
         begin : g_rest
            assign upper[gi] = eff_en[gi-1] & eff_w64[gi-1];
            assign up_mask = low_mask[gi-1][63:32];
         end
         if (gi == NSLOT - 1)
         begin : g_last
            assign base64 = {32'h0, base_r[gi]};
         end
         else
         begin : g_pair
            assign base64 = eff_w64[gi] ? {base_r[gi+1], base_r[gi]} : {32'h0, base_r[gi]};
         end

         pbcd_slot_check #(.SLOT(gi)) u_chk
         (
            .setup(setup_r[gi]),
            .port(ctrl_r),
            .upper(upper[gi]),
            .en(eff_en[gi]),
            .io(eff_io[gi]),
            .w64(eff_w64[gi]),
            .pf(eff_pf[gi]),
            .size(eff_size[gi]),
            .err(eff_err[gi])
         );

         pbcd_addr_match u_match
         (
            .en(eff_en[gi] && (eff_io[gi] == REQ_IO)),
            .base(base64),
            .size(eff_size[gi]),
            .addr(REQ_ADDR),
            .hit(hit[gi])
         );

         assign low_mask[gi] = (64'h1 << eff_size[gi]) - 64'h1;

         always_comb
         begin
            rb[gi] = 32'h0;
            if (eff_en[gi])
            begin
               rb[gi] = base_nxt[gi] & ~low_mask[gi][31:0];
               rb[gi][B_IO] = eff_io[gi];
               rb[gi][2:1] = eff_w64[gi] ? B_TYPE64 : 2'h0;
               rb[gi][B_PF] = eff_pf[gi];
            end
            else if (upper[gi])
            begin
               rb[gi] = base_nxt[gi] & ~up_mask;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Expansion ROM window; ROM claims also need the decode bit in its BAR word

   logic rom_en;
   logic rom_big;
   logic rom_hit;
   logic [5:0] rom_raw;
   logic [5:0] rom_size;
   logic [63:0] rom_mask;

   always_comb
   begin
      rom_en = setup_r[CLAIM_ROM][F_EN];
      rom_raw = setup_r[CLAIM_ROM][F_SZ +: SZ_W];
      rom_size = (rom_raw < ROM_MIN) ? ROM_MIN : ((rom_raw > ROM_MAX) ? ROM_MAX : rom_raw);
      rom_big = rom_en && (rom_size > ROM_ADVISE);
      rom_mask = (64'h1 << rom_size) - 64'h1;
      rb[CLAIM_ROM] = 32'h0;
      if (rom_en)
      begin
         rb[CLAIM_ROM] = base_nxt[CLAIM_ROM] & ~rom_mask[31:0];
         rb[CLAIM_ROM][B_ROMDEC] = base_nxt[CLAIM_ROM][B_ROMDEC];
      end
   end

   pbcd_addr_match u_rom_match
   (
      .en(rom_en && base_r[CLAIM_ROM][B_ROMDEC] && !REQ_IO),
      .base({32'h0, base_r[CLAIM_ROM]}),
      .size(rom_size),
      .addr(REQ_ADDR),
      .hit(rom_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data; control, setup and BAR base words taken from next-state values so a read right after a write sees it; status uses registered setup

   logic [31:0] status;

   always_comb
   begin
      status = 32'h0;
      status[S_EN +: NSLOT] = eff_en;
      status[S_EN + NSLOT] = rom_en;
      status[S_ERR +: NSLOT] = eff_err;
      status[S_ROMBIG] = rom_big;
      hrdata_nxt = hrdata_r;
      if (ap && !HWRITE)
      begin
         hrdata_nxt = 32'h0;
         if (mapped)
         begin
            if (HADDR[7:0] == A_CTRL)
            begin
               hrdata_nxt = {30'h0, ctrl_nxt};
            end
            if (HADDR[7:0] == A_STATUS)
            begin
               hrdata_nxt = status;
            end
            if (in_block(HADDR[7:0], A_SETUP0))
            begin
               hrdata_nxt = {22'h0, setup_nxt[blk_idx(HADDR[7:0], A_SETUP0)]};
            end
            if (in_block(HADDR[7:0], A_BAR0))
            begin
               hrdata_nxt = rb[blk_idx(HADDR[7:0], A_BAR0)];
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         hrdata_r <= 32'h0;
      end
      else
      begin
         hrdata_r <= hrdata_nxt;
      end
   end

   assign HRDATA = hrdata_r;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Claim; lowest slot wins, ROM last

   logic cv_r;
   logic cv_nxt;
   logic ch_r;
   logic ch_nxt;
   logic [2:0] cb_r;
   logic [2:0] cb_nxt;
   logic cp_r;
   logic cp_nxt;

   always_comb
   begin
      cv_nxt = REQ_VALID;
      ch_nxt = 1'b0;
      cb_nxt = 3'h0;
      cp_nxt = 1'b0;
      if (REQ_VALID && rom_hit)
      begin
         ch_nxt = 1'b1;
         cb_nxt = CLAIM_ROM;
      end
      for (int i = NSLOT - 1; i >= 0; i--)
      begin
         if (REQ_VALID && hit[i])
         begin
            ch_nxt = 1'b1;
            cb_nxt = 3'(i);
            cp_nxt = eff_pf[i];
         end
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         cv_r <= 1'b0;
         ch_r <= 1'b0;
         cb_r <= 3'h0;
         cp_r <= 1'b0;
      end
      else
      begin
         cv_r <= cv_nxt;
         ch_r <= ch_nxt;
         cb_r <= cb_nxt;
         cp_r <= cp_nxt;
      end
   end

   assign CLAIM_VALID = cv_r;
   assign CLAIM_HIT = ch_r;
   assign CLAIM_BAR = cb_r;
   assign CLAIM_PREFETCH = cp_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [NSLOT-1:0] io_prev_r;
   logic [NSLOT-1:0] en_prev_r;

   always_ff @(posedge SYS_CLK)
   begin
      io_prev_r <= eff_io;
      en_prev_r <= eff_en;
   end

   AST_ROOT_SLOTS: assert property (@(posedge SYS_CLK) disable iff (SRST)
      ctrl_r == PBCD_ROOT |-> eff_en[NSLOT-1:RP_SLOTS] == '0)
      else $error("Root Port enables a BAR above slot one");

   AST_CLAIM_CODE: assert property (@(posedge SYS_CLK) disable iff (SRST)
      REQ_VALID |=> CLAIM_VALID && (!CLAIM_HIT || CLAIM_BAR <= CLAIM_ROM))
      else $error("Claim missing or claim code out of range");

   AST_IO_LEGACY: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (eff_en & eff_io) != '0 |-> ctrl_r == PBCD_LEGACY)
      else $error("I/O BAR enabled outside Legacy Endpoint");

   AST_IO_PLAIN: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (eff_io & (eff_w64 | eff_pf)) == '0)
      else $error("I/O BAR is 64-bit or prefetchable");

   AST_PF_WIDE: assert property (@(posedge SYS_CLK) disable iff (SRST)
      ctrl_r != PBCD_LEGACY |-> (eff_en[NSLOT-2:0] & eff_pf[NSLOT-2:0] & ~eff_w64[NSLOT-2:0]) == '0)
      else $error("Prefetchable 32-bit BAR below BAR5 in Endpoint");

   AST_CLAIM_SPACE: assert property (@(posedge SYS_CLK) disable iff (SRST)
      CLAIM_HIT && CLAIM_BAR < CLAIM_ROM |-> io_prev_r[CLAIM_BAR] == $past(REQ_IO))
      else $error("Claim crosses address space type");

   AST_CLAIM_ENABLED: assert property (@(posedge SYS_CLK) disable iff (SRST)
      CLAIM_HIT && CLAIM_BAR < CLAIM_ROM |-> en_prev_r[CLAIM_BAR])
      else $error("Disabled BAR claimed a request");

   AST_ROM_RANGE: assert property (@(posedge SYS_CLK) disable iff (SRST)
      rom_size >= ROM_MIN && rom_size <= ROM_MAX && (rom_big == (rom_en && rom_size > ROM_ADVISE)))
      else $error("ROM window size out of range");

   generate
      for (gi = 0; gi < NSLOT; gi++)
      begin : g_ast
         AST_SIZE_LIMIT: assert property (@(posedge SYS_CLK) disable iff (SRST)
            eff_en[gi] |-> eff_size[gi] >= (ctrl_r == PBCD_LEGACY ? SZ_MIN_LEG : SZ_MIN_EP)
               && eff_size[gi] <= (eff_w64[gi] ? SZ_MAX64 : SZ_MAX32))
            else $error("BAR window size outside its limits");
         AST_LOW_ZERO: assert property (@(posedge SYS_CLK) disable iff (SRST)
            eff_en[gi] |-> (rb[gi] & low_mask[gi][31:0] & 32'hffff_fff0) == 32'h0)
            else $error("BAR low address bits not zero");
         if (gi < NSLOT - 1)
         begin : g_pair_ast
            AST_UPPER_HALF: assert property (@(posedge SYS_CLK) disable iff (SRST)
               eff_en[gi] && eff_w64[gi] |-> !eff_en[gi+1] && upper[gi+1])
               else $error("Upper half slot still independent");
         end
      end
   endgenerate

endmodule

// ==== verif/pbcd_link_partner.sv ====
// Link partner model that issues memory and I/O requests toward the decoder
`timescale 1ns/1ns
module pbcd_link_partner
(
   // Clock
   input wire logic clk,
   // Request toward the decoder
   output logic req_valid,
   output logic [63:0] req_addr,
   output logic req_io,
   // Claim answer
   input wire logic claim_valid,
   input wire logic claim_hit,
   input wire logic [2:0] claim_bar,
   input wire logic claim_prefetch
);
   initial
   begin
      req_valid = 1'b0;
      req_addr = 64'h0;
      req_io = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Released lines show the inverse, so a stale address is never claimed by luck
   task automatic send(input logic [63:0] a, input logic io, output logic v,
      output logic h, output logic [2:0] b, output logic p);
      @(posedge clk);
      req_valid <= 1'b1;
      req_addr <= a;
      req_io <= io;
      @(posedge clk);
      req_valid <= 1'b0;
      req_addr <= ~a;
      req_io <= ~io;
      // The claim stands for one cycle only; take it at the edge that ends it
      @(posedge clk);
      v = claim_valid;
      h = claim_hit;
      b = claim_bar;
      p = claim_prefetch;
   endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench of the BAR decode block
`timescale 1ns/1ns
`define CHK(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
      end \
   end
module tb;
   import pbcd_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, req_valid, req_io;
   logic [63:0] req_addr;
   logic claim_valid, claim_hit, claim_prefetch;
   logic [2:0] claim_bar;
   int errors = 0;
   int comparisons = 0;

   always #50 sys_clk = ~sys_clk;

   pbcd_bar_decode dut
   (
      .SYS_CLK(sys_clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .REQ_VALID(req_valid),
      .REQ_ADDR(req_addr), .REQ_IO(req_io), .CLAIM_VALID(claim_valid),
      .CLAIM_HIT(claim_hit), .CLAIM_BAR(claim_bar), .CLAIM_PREFETCH(claim_prefetch)
   );

   pbcd_link_partner lp
   (
      .clk(sys_clk), .req_valid(req_valid), .req_addr(req_addr), .req_io(req_io),
      .claim_valid(claim_valid), .claim_hit(claim_hit), .claim_bar(claim_bar),
      .claim_prefetch(claim_prefetch)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic do_reset();
      srst <= 1'b1;
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb_xfer(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      ahb_xfer(1'b0, a, 32'h0, q);
      `CHK($sformatf("reg %h", a), exp, q)
      `CHK("okay response", 1'b0, hresp)
   endtask

   task automatic claim_chk(input logic [63:0] a, input logic io, input logic h,
      input logic [2:0] b, input logic p);
      logic v, gh, gp;
      logic [2:0] gb;
      lp.send(a, io, v, gh, gb, gp);
      `CHK("claim valid", 1'b1, v)
      `CHK("claim hit", h, gh)
      `CHK("claim bar", b, gb)
      `CHK("claim prefetch", p, gp)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      do_reset();
      rd_chk(A_CTRL, 32'h0);
      rd_chk(A_STATUS, 32'h0);
      rd_chk(A_BAR0, 32'h0);
      // Unmapped word swallows writes and reads back zero
      wr(8'h80, 32'hffff_ffff);
      rd_chk(8'h80, 32'h0);
      claim_chk(64'h0, 1'b0, 1'b0, 3'h0, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_ep32();
      do_reset();
      wr(A_SETUP0, 32'h41);
      wr(A_BAR0, 32'hffff_ffff);
      rd_chk(A_BAR0, 32'hffff_ff80);
      wr(A_SETUP0, 32'h281);
      wr(A_BAR0, 32'hffff_ffff);
      rd_chk(A_BAR0, 32'h8000_0000);
      wr(A_SETUP0, 32'h71);
      wr(A_BAR0, 32'h1000);
      rd_chk(A_STATUS, 32'h1);
      claim_chk(64'h107f, 1'b0, 1'b1, 3'h0, 1'b0);
      claim_chk(64'h1080, 1'b0, 1'b0, 3'h0, 1'b0);
      claim_chk(64'h1000, 1'b1, 1'b0, 3'h0, 1'b0);
      wr(A_SETUP0, 32'h70);
      wr(A_BAR0, 32'h1000);
      claim_chk(64'h1000, 1'b0, 1'b0, 3'h0, 1'b0);
      $display("test endpoint 32-bit done");
   endtask

   task automatic t_ep64();
      do_reset();
      wr(A_SETUP0 + 8'h08, 32'h20d);
      wr(A_SETUP0 + 8'h0c, 32'h71);
      wr(A_BAR0 + 8'h08, 32'hffff_ffff);
      rd_chk(A_BAR0 + 8'h08, 32'h0000_000c);
      wr(A_BAR0 + 8'h0c, 32'h1);
      rd_chk(A_STATUS, 32'h4);
      rd_chk(A_BAR0 + 8'h0c, 32'h1);
      claim_chk(64'h1_0000_0010, 1'b0, 1'b1, 3'h2, 1'b1);
      claim_chk(64'h2_0000_0010, 1'b0, 1'b0, 3'h0, 1'b0);
      claim_chk(64'h1_0000_0010, 1'b1, 1'b0, 3'h0, 1'b0);
      $display("test endpoint 64-bit done");
   endtask

   task automatic t_legal();
      do_reset();
      wr(A_SETUP0 + 8'h04, 32'h43);
      wr(A_BAR0 + 8'h04, 32'h0);
      rd_chk(A_STATUS, 32'h200);
      wr(A_SETUP0 + 8'h04, 32'h79);
      wr(A_SETUP0 + 8'h14, 32'h75);
      wr(A_BAR0 + 8'h04, 32'h0);
      rd_chk(A_STATUS, 32'h2200);
      wr(A_SETUP0 + 8'h14, 32'h79);
      wr(A_BAR0 + 8'h14, 32'h4000);
      rd_chk(A_STATUS, 32'h220);
      wr(A_CTRL, 32'h1);
      wr(A_CTRL, 32'h3);
      rd_chk(A_CTRL, 32'h1);
      wr(A_SETUP0 + 8'h04, 32'h4f);
      wr(A_BAR0 + 8'h04, 32'hffff_ffff);
      rd_chk(A_BAR0 + 8'h04, 32'hffff_fff1);
      rd_chk(A_STATUS, 32'h22);
      wr(A_BAR0 + 8'h04, 32'h2000);
      claim_chk(64'h2008, 1'b1, 1'b1, 3'h1, 1'b0);
      claim_chk(64'h2008, 1'b0, 1'b0, 3'h0, 1'b0);
      claim_chk(64'h4010, 1'b0, 1'b1, 3'h5, 1'b1);
      $display("test legality and legacy done");
   endtask

   task automatic t_root();
      do_reset();
      wr(A_CTRL, 32'h2);
      wr(A_SETUP0, 32'h71);
      wr(A_SETUP0 + 8'h04, 32'h71);
      wr(A_SETUP0 + 8'h08, 32'h71);
      wr(A_BAR0, 32'h0);
      rd_chk(A_STATUS, 32'h403);
      wr(A_SETUP0, 32'h75);
      wr(A_BAR0, 32'h0);
      rd_chk(A_STATUS, 32'h401);
      $display("test root port done");
   endtask

   task automatic t_rom();
      do_reset();
      wr(A_SETUP0 + 8'h18, 32'ha1);
      wr(A_BAR0 + 8'h18, 32'hffff_ffff);
      rd_chk(A_BAR0 + 8'h18, 32'hffff_f801);
      rd_chk(A_STATUS, 32'h40);
      wr(A_BAR0 + 8'h18, 32'h0010_0001);
      claim_chk(64'h10_0400, 1'b0, 1'b1, CLAIM_ROM, 1'b0);
      wr(A_SETUP0 + 8'h18, 32'h191);
      wr(A_BAR0 + 8'h18, 32'h0010_0001);
      rd_chk(A_STATUS, 32'h1_0040);
      $display("test expansion rom done");
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      t_reset();
      t_ep32();
      t_ep64();
      t_legal();
      t_root();
      t_rom();
      report_and_stop();
   end

   // A hung handshake must still end the run with a verdict
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      report_and_stop();
   end
endmodule
